// ===== verilog/ssrg_consts.svh
// Purpose: Constants of the sync request generator
// Assumes: One mclk cycle is one octet time on the link
// Notes: Definitions only
//
// Notes on behaviour
// - Read-only byte shows empty flag per lane
// - Multiframe mask bit gates lane 0 multiframe loss
// - Mask clear: no sync low on multiframe loss
// - Frame mask bit gates lane 0 frame loss
// - Error low: half PCLK plus four octets/step
// - Request low: 5 frames+9 octets, +4/step
// - Read-only byte reports multiframe period in PCLK
`ifndef SSRG_CONSTS_SVH
`define SSRG_CONSTS_SVH

// Register offsets
`define SSRG_ADDR_FIFO_EMPTY 12'h30d
`define SSRG_ADDR_LOSS_MASK 12'h311
`define SSRG_ADDR_LOW_DUR 12'h312
`define SSRG_ADDR_MF_PERIOD 12'h313
`define SSRG_ADDR_IRQ_STATUS 12'h320
`define SSRG_ADDR_IRQ_MASK 12'h321
`define SSRG_ADDR_FRAME_OCT 12'h322

// Reset values
`define SSRG_RST_BYTE 8'h00
`define SSRG_RST_MASK 3'h0
`define SSRG_RST_EV 4'h0
`define SSRG_RST_CNT 12'h000
`define SSRG_RST_CYC 10'h000

// Field positions
`define SSRG_BIT_MF_MASK 2
`define SSRG_BIT_F_MASK 0
`define SSRG_EV_FLOSS 0
`define SSRG_EV_MFLOSS 1
`define SSRG_EV_REQ 2
`define SSRG_EV_ERR 3

// Timing counts in octets
`define SSRG_REQ_FRAMES 12'h005
`define SSRG_REQ_EXTRA 12'h009
`define SSRG_ERR_BASE 12'h002
`define SSRG_OCT_PER_PCLK 12'h004
`define SSRG_ONE 12'h001
`define SSRG_CYC_SAT 10'h3ff
`define SSRG_CYC_ONE 10'h001

`endif

// ===== verilog/ssrg_pkg.sv
// Purpose: Types of the sync request generator
// Assumes: Nothing
// Notes: Constants live in ssrg_consts.svh
package ssrg_pkg;

  typedef enum logic [1:0] {
    SSRG_IDLE = 2'b00,
    SSRG_REQ_LOW = 2'b01,
    SSRG_ERR_LOW = 2'b10
  } ssrg_state_t;

  typedef struct packed {
    logic mf_mask;
    logic spare;
    logic f_mask;
  } ssrg_mask_t;

  typedef struct packed {
    logic [3:0] err_dur;
    logic [3:0] req_dur;
  } ssrg_dur_t;

  typedef struct packed {
    logic frame_loss;
    logic mframe_loss;
    logic sync_req;
    logic err_rpt;
    logic lmfc_edge;
  } ssrg_lane0_t;

endpackage

// ===== verilog/ssrg_low_timer.sv
// Purpose: Down counter timing the low phase of the sync output
// Assumes: load has priority over counting
// Notes: Count stops at zero
`timescale 1ns/1ns
`include "ssrg_consts.svh"
module ssrg_low_timer
  import ssrg_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire logic load,
  input wire logic [11:0] load_val,
  // Status
  output logic [11:0] count
);

  logic [11:0] count_reg;
  logic [11:0] count_next;

  always_comb begin
    if (load) begin
      count_next = load_val;
    end else if (count_reg != `SSRG_RST_CNT) begin
      count_next = count_reg - `SSRG_ONE;
    end else begin
      count_next = count_reg;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= `SSRG_RST_CNT;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule

// ===== verilog/ssrg_top.sv
// Purpose: Sync request generation and lane status registers
// Assumes: Lane 0 loss events and error reports arrive as pulses
// Notes: sync_request_output_n is active low
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "ssrg_consts.svh"
module ssrg_top
  import ssrg_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Lane status and lane 0 events
  input wire logic [7:0] lane_fifo_empty,
  input wire ssrg_lane0_t lane0_ev,
  // Link and interrupt
  output logic sync_request_output_n,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  ssrg_mask_t mask_reg;
  ssrg_mask_t mask_next;
  ssrg_dur_t dur_reg;
  ssrg_dur_t dur_next;
  logic [7:0] frame_oct_reg;
  logic [7:0] frame_oct_next;
  logic [3:0] ev_reg;
  logic [3:0] ev_next;
  logic [3:0] ev_mask_reg;
  logic [3:0] ev_mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  logic [3:0] ev_set;

  always_comb begin
    mask_next = mask_reg;
    dur_next = dur_reg;
    frame_oct_next = frame_oct_reg;
    ev_mask_next = ev_mask_reg;
    ev_next = ev_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        `SSRG_ADDR_LOSS_MASK: begin
          mask_next = reg_wdata[2:0];
        end
        `SSRG_ADDR_LOW_DUR: begin
          dur_next = reg_wdata;
        end
        `SSRG_ADDR_FRAME_OCT: begin
          frame_oct_next = reg_wdata;
        end
        `SSRG_ADDR_IRQ_MASK: begin
          ev_mask_next = reg_wdata[3:0];
        end
        `SSRG_ADDR_IRQ_STATUS: begin
          ev_next = ev_reg & ~reg_wdata[3:0];
        end
        default: begin
          ev_next = ev_reg;
        end
      endcase
    end
    ev_next = ev_next | ev_set;
    irq_next = |(ev_next & ev_mask_next);
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  logic [7:0] period_reg;

  always_comb begin
    rdata_next = `SSRG_RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        `SSRG_ADDR_FIFO_EMPTY: rdata_next = lane_fifo_empty;
        `SSRG_ADDR_LOSS_MASK: rdata_next = {5'h00, mask_reg};
        `SSRG_ADDR_LOW_DUR: rdata_next = dur_reg;
        `SSRG_ADDR_MF_PERIOD: rdata_next = period_reg;
        `SSRG_ADDR_IRQ_STATUS: rdata_next = {4'h0, ev_reg};
        `SSRG_ADDR_IRQ_MASK: rdata_next = {4'h0, ev_mask_reg};
        `SSRG_ADDR_FRAME_OCT: rdata_next = frame_oct_reg;
        default: rdata_next = `SSRG_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= `SSRG_RST_MASK;
      dur_reg <= `SSRG_RST_BYTE;
      frame_oct_reg <= `SSRG_RST_BYTE;
      ev_reg <= `SSRG_RST_EV;
      ev_mask_reg <= `SSRG_RST_EV;
      rdata_reg <= `SSRG_RST_BYTE;
      irq_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      dur_reg <= dur_next;
      frame_oct_reg <= frame_oct_next;
      ev_reg <= ev_next;
      ev_mask_reg <= ev_mask_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sync output state machine

  ssrg_state_t state_reg;
  ssrg_state_t state_next;
  logic sync_n_reg;
  logic sync_n_next;
  logic req_trig;
  logic f_trig;
  logic mf_trig;
  logic load;
  logic [11:0] load_val;
  logic [11:0] count;
  logic [11:0] frame_len;
  logic [11:0] req_len;
  logic [11:0] err_len;

  assign f_trig = lane0_ev.frame_loss & mask_reg.f_mask;
  assign mf_trig = lane0_ev.mframe_loss & mask_reg.mf_mask;
  assign req_trig = f_trig | mf_trig | lane0_ev.sync_req;
  assign frame_len = {4'h0, frame_oct_reg} + `SSRG_ONE;
  assign req_len = frame_len * `SSRG_REQ_FRAMES + `SSRG_REQ_EXTRA
    + {8'h00, dur_reg.req_dur} * `SSRG_OCT_PER_PCLK;
  assign err_len = `SSRG_ERR_BASE
    + {8'h00, dur_reg.err_dur} * `SSRG_OCT_PER_PCLK;

  always_comb begin
    state_next = state_reg;
    load = 1'b0;
    load_val = req_len;
    unique case (state_reg)
      SSRG_IDLE: begin
        if (req_trig) begin
          state_next = SSRG_REQ_LOW;
          load = 1'b1;
        end else if (lane0_ev.err_rpt) begin
          state_next = SSRG_ERR_LOW;
          load = 1'b1;
          load_val = err_len;
        end
      end
      SSRG_REQ_LOW: begin
        if (count == `SSRG_ONE) begin
          state_next = SSRG_IDLE;
        end
      end
      SSRG_ERR_LOW: begin
        if (req_trig) begin
          state_next = SSRG_REQ_LOW;
          load = 1'b1;
        end else if (count == `SSRG_ONE) begin
          state_next = SSRG_IDLE;
        end
      end
      default: begin
        state_next = SSRG_IDLE;
      end
    endcase
    sync_n_next = (state_next == SSRG_IDLE);
  end

  assign ev_set = {
    load & (state_next == SSRG_ERR_LOW),
    load & (state_next == SSRG_REQ_LOW),
    lane0_ev.mframe_loss,
    lane0_ev.frame_loss
  };

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= SSRG_IDLE;
      sync_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      sync_n_reg <= sync_n_next;
    end
  end

  ssrg_low_timer u_timer (
    .mclk(mclk),
    .resetn(resetn),
    .load(load),
    .load_val(load_val),
    .count(count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Multiframe clock period measure

  logic [9:0] cyc_reg;
  logic [9:0] cyc_next;
  logic [9:0] cyc_inc;
  logic [7:0] period_next;

  always_comb begin
    cyc_inc = (cyc_reg == `SSRG_CYC_SAT) ? cyc_reg : cyc_reg + `SSRG_CYC_ONE;
    cyc_next = cyc_inc;
    period_next = period_reg;
    if (lane0_ev.lmfc_edge) begin
      cyc_next = `SSRG_RST_CYC;
      period_next = cyc_inc[9:2];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cyc_reg <= `SSRG_RST_CYC;
      period_reg <= `SSRG_RST_BYTE;
    end else begin
      cyc_reg <= cyc_next;
      period_reg <= period_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sync_request_output_n = sync_n_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [11:0] low_run_reg;
  logic [11:0] len_hold_reg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_run_reg <= `SSRG_RST_CNT;
      len_hold_reg <= `SSRG_RST_CNT;
    end else begin
      low_run_reg <= sync_n_reg ? `SSRG_RST_CNT : low_run_reg + `SSRG_ONE;
      if (load) begin
        len_hold_reg <= load_val
          + (sync_n_reg ? `SSRG_RST_CNT : low_run_reg + `SSRG_ONE);
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_idle_quiet;
    state_reg == SSRG_IDLE && !lane0_ev.sync_req && !lane0_ev.err_rpt;
  endsequence

  sequence s_err_pulse_min;
    !sync_request_output_n [*2];
  endsequence

  a_fifo_empty_read: assert property (
    reg_rd && reg_addr == `SSRG_ADDR_FIFO_EMPTY
    |=> reg_rdata == $past(lane_fifo_empty))
    else $error("fifo empty flags misread");

  a_mf_loss_drive: assert property (
    state_reg == SSRG_IDLE && lane0_ev.mframe_loss && mask_reg.mf_mask
    |=> !sync_request_output_n)
    else $error("multiframe loss did not drive sync low");

  a_mf_loss_masked: assert property (
    s_idle_quiet ##0 (lane0_ev.mframe_loss && !mask_reg.mf_mask
    && !f_trig) |=> sync_request_output_n)
    else $error("masked multiframe loss drove sync low");

  a_frame_loss_gate: assert property (
    s_idle_quiet ##0 (lane0_ev.frame_loss && !mf_trig)
    |=> sync_request_output_n == !mask_reg.f_mask)
    else $error("frame loss gating wrong");

  a_err_low_min: assert property (
    state_reg == SSRG_IDLE && lane0_ev.err_rpt && !req_trig
    |=> s_err_pulse_min)
    else $error("error report low too short");

  a_err_len_zero: assert property (
    state_reg == SSRG_IDLE && lane0_ev.err_rpt && !req_trig
    && dur_reg.err_dur == 4'h0 ##1 !req_trig ##1 !req_trig
    |-> ##1 sync_request_output_n && !$past(sync_request_output_n)
    && !$past(sync_request_output_n, 2))
    else $error("error low not two octets");

  a_low_run_len: assert property (
    $rose(sync_request_output_n) |-> low_run_reg == len_hold_reg)
    else $error("sync low length wrong");

  a_req_start: assert property (
    state_reg == SSRG_IDLE && req_trig
    |=> !sync_request_output_n ##0 count == $past(req_len))
    else $error("sync request did not start");

  a_period_capture: assert property (
    lane0_ev.lmfc_edge
    |=> {2'b00, period_reg} == ($past(cyc_inc) >> 2)
    && cyc_reg == `SSRG_RST_CYC)
    else $error("multiframe period not captured");

  a_irq_level: assert property (
    irq == |(ev_reg & ev_mask_reg))
    else $error("interrupt level wrong");

endmodule

// ===== verif/ssrg_tx_model.sv
// Purpose: Transmitter model measuring sync low spans
// Assumes: Sync output sampled at mclk rising edge
// Notes: Reports each low span length when it ends
`timescale 1ns/1ns
module ssrg_tx_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link
  input wire logic sync_n,
  // Report
  output logic [11:0] low_len,
  output logic low_done
);
  logic [11:0] cnt_reg;
  //////////////////////////////////////////////////////////////////////////
  // Low level taken as request or error report
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 12'h000;
      low_len <= 12'h000;
      low_done <= 1'b0;
    end else begin
      low_done <= 1'b0;
      if (!sync_n) begin
        cnt_reg <= cnt_reg + 12'h001;
      end else if (cnt_reg != 12'h000) begin
        low_len <= cnt_reg;
        low_done <= 1'b1;
        cnt_reg <= 12'h000;
      end
    end
  end
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench of the sync request generator
// Assumes: One mclk cycle is one octet
// Notes: Expected results queued, compared by a watcher
`timescale 1ns/1ns
`include "ssrg_consts.svh"
module testbench import ssrg_pkg::*;;
  logic mclk, resetn, reg_wr, reg_rd, sync_n, irq, low_done, rd_prev;
  logic [11:0] reg_addr, low_len;
  logic [7:0] reg_wdata, reg_rdata, lane_fifo_empty;
  ssrg_lane0_t lane0_ev;
  int error_cnt, tests_run;
  logic [7:0] rq[$];
  logic [11:0] sq[$];
  logic iq[$];
  //////////////////////////////////////////////////////////////////////////
  ssrg_top DUT (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lane_fifo_empty(lane_fifo_empty),
    .lane0_ev(lane0_ev), .sync_request_output_n(sync_n), .irq(irq));
  ssrg_tx_model tx (.mclk(mclk), .resetn(resetn), .sync_n(sync_n),
    .low_len(low_len), .low_done(low_done));
  //////////////////////////////////////////////////////////////////////////
  task automatic cmp(string nm, logic [11:0] e, logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_rdata(logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value reg_rdata expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_irq(logic e, logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value irq expected %b seen %b", e, g);
    end
  endtask
  task automatic end_of_test();
    $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [7:0] e);
    rq.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(int b);
    @(posedge mclk);
    lane0_ev <= ssrg_lane0_t'(5'(1 << b));
    @(posedge mclk);
    lane0_ev <= 5'h00;
  endtask
  task automatic ev(int b, logic [11:0] e);
    if (e != 12'h000) sq.push_back(e);
    pulse(b);
    for (int i = 0; i < 300 && sq.size() > 0; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask
  task automatic chk_irq(logic e);
    iq.push_back(e);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(negedge mclk) begin
    if (rd_prev) cmp_rdata(rq.pop_front(), reg_rdata);
    if (iq.size() > 0) cmp_irq(iq.pop_front(), irq);
    if (low_done) cmp("low_len", sq.size() ? sq.pop_front() : 12'hfff, low_len);
    rd_prev = reg_rd;
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v;
    resetn = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lane_fifo_empty = 8'h00;
    lane0_ev = 5'h00;
    rd_prev = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    v = 8'($urandom(32'hdbfb));
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    // Reset values and unmapped place
    rd(`SSRG_ADDR_LOSS_MASK, 8'h00);
    rd(`SSRG_ADDR_LOW_DUR, 8'h00);
    rd(`SSRG_ADDR_MF_PERIOD, 8'h00);
    rd(`SSRG_ADDR_FIFO_EMPTY, 8'h00);
    wr(12'h300, 8'h5a);
    rd(12'h300, 8'h00);
    wr(`SSRG_ADDR_FIFO_EMPTY, 8'hff);
    rd(`SSRG_ADDR_FIFO_EMPTY, 8'h00);
    repeat (3) begin
      v = 8'($urandom);
      lane_fifo_empty <= v;
      rd(`SSRG_ADDR_FIFO_EMPTY, v);
    end
    // Low durations
    for (int d = 0; d < 3; d++) begin
      wr(`SSRG_ADDR_LOW_DUR, 8'(d));
      ev(2, 12'(14 + 4 * d));
    end
    for (int d = 0; d < 2; d++) begin
      wr(`SSRG_ADDR_LOW_DUR, 8'(d << 4));
      ev(1, 12'(2 + 4 * d));
    end
    wr(`SSRG_ADDR_LOW_DUR, 8'h00);
    ev(3, 12'h000);
    ev(4, 12'h000);
    rd(`SSRG_ADDR_IRQ_STATUS, 8'h0f);
    chk_irq(1'b0);
    // Mask bits enabled
    wr(`SSRG_ADDR_LOSS_MASK, 8'hff);
    rd(`SSRG_ADDR_LOSS_MASK, 8'h07);
    ev(3, 12'd14);
    ev(4, 12'd14);
    wr(`SSRG_ADDR_FRAME_OCT, 8'h01);
    ev(2, 12'd19);
    wr(`SSRG_ADDR_FRAME_OCT, 8'h00);
    // Request during request low ignored
    sq.push_back(12'd14);
    pulse(2);
    repeat (3) @(posedge mclk);
    ev(2, 12'h000);
    // Request during error low restarts as a full request
    wr(`SSRG_ADDR_LOW_DUR, 8'h30);
    sq.push_back(12'd19);
    pulse(1);
    repeat (3) @(posedge mclk);
    ev(2, 12'h000);
    wr(`SSRG_ADDR_LOW_DUR, 8'h00);
    // Interrupt raise, mask, clear
    wr(`SSRG_ADDR_IRQ_STATUS, 8'h0f);
    wr(`SSRG_ADDR_IRQ_MASK, 8'h04);
    chk_irq(1'b0);
    ev(2, 12'd14);
    chk_irq(1'b1);
    rd(`SSRG_ADDR_IRQ_STATUS, 8'h04);
    wr(`SSRG_ADDR_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge mclk);
    chk_irq(1'b0);
    // Multiframe clock period, 41 cycles apart
    pulse(0);
    repeat (39) @(posedge mclk);
    pulse(0);
    repeat (2) @(posedge mclk);
    rd(`SSRG_ADDR_MF_PERIOD, 8'd10);
    repeat (3) @(posedge mclk);
    cmp("pending", 12'h000, 12'(sq.size()));
    cmp("pending_rd", 12'h000, 12'(rq.size() + iq.size()));
    end_of_test();
  end
endmodule
